// >>> hw/rsh_list_mem.sv
// Small memory holding the pending channel close list
`default_nettype none
module rsh_list_mem #(
    parameter int unsigned DW = 5,
    parameter int unsigned AW = 4
) (
    // Clock
    input wire logic clock_in,
    // Write port
    input wire logic wr_in,
    input wire logic [AW-1:0] waddr_in,
    input wire logic [DW-1:0] wdata_in,
    // Read port
    input wire logic [AW-1:0] raddr_in,
    output logic [DW-1:0] rdata_out
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clock_in) begin
        if (wr_in) begin
            mem[waddr_in] <= wdata_in;
        end
    end

    always_ff @(posedge clock_in) begin
        rdata_out <= mem[raddr_in];
    end
endmodule : rsh_list_mem
`default_nettype wire

// >>> hw/rsh_pkg.sv
// Package: constants and carriers for the relay safety handler block
`default_nettype none
package rsh_pkg;
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned CHAN_COUNT = 24;
    localparam int unsigned CHW = 5;
    localparam int unsigned LIST_DEPTH = 16;
    localparam int unsigned LIST_AW = 4;
    localparam int unsigned BLEED_MS = 5;
    localparam int unsigned BLEED_CYCLES = CLK_HZ / 1000 * BLEED_MS;
    localparam int unsigned SETTLE_MS = 5;
    localparam int unsigned SETTLE_CYCLES = CLK_HZ / 1000 * SETTLE_MS;
    localparam int unsigned RELAY_STEP_CYCLES = 16;
    localparam logic [15:0] VSRC_MAX_V = 16'd500;
    localparam logic [15:0] ISRC_MAX_MA = 16'd50;
    // Channel numbers with special duties
    localparam logic [CHW-1:0] CH_SHUNT_A = 5'd3;
    localparam logic [CHW-1:0] CH_SHUNT_B = 5'd6;
    localparam logic [CHW-1:0] CH_SHUNT_C = 5'd9;
    localparam logic [CHW-1:0] CH_SHUNT_D = 5'd12;
    localparam logic [CHW-1:0] CH_METER = 5'd18;
    localparam logic [CHW-1:0] CH_BACKPLANE = 5'd19;
    localparam logic [CHW-1:0] CH_SRC_CONN = 5'd21;
    localparam logic [CHW-1:0] CH_SRC_SEL = 5'd22;
    // Register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LIST_PUSH = 8'h04;
    localparam logic [7:0] REG_CMD = 8'h08;
    localparam logic [7:0] REG_OPEN_ONE = 8'h0C;
    localparam logic [7:0] REG_VSRC = 8'h10;
    localparam logic [7:0] REG_ISRC = 8'h14;
    localparam logic [7:0] REG_HI1 = 8'h18;
    localparam logic [7:0] REG_HI2 = 8'h1C;
    localparam logic [7:0] REG_LO1 = 8'h20;
    localparam logic [7:0] REG_LO2 = 8'h24;
    localparam logic [7:0] REG_RELAYS = 8'h28;
    localparam logic [7:0] REG_STATUS = 8'h2C;
    localparam logic [7:0] REG_RESULT = 8'h30;
    // Control bit positions
    localparam int unsigned CTRL_BLEED = 0;
    localparam int unsigned CTRL_POL_LOW = 1;
    localparam int unsigned CTRL_MATH = 2;
    // Command bit positions
    localparam int unsigned CMD_CLOSE_LIST = 0;
    localparam int unsigned CMD_OPEN_ALL = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } rsh_bus_s;

    typedef struct packed {
        logic hi1;
        logic hi2;
        logic lo1;
        logic lo2;
        logic master;
    } rsh_limit_s;

    typedef enum logic [2:0] {
        RSH_IDLE = 3'b000,
        RSH_CLOSE = 3'b001,
        RSH_STEP = 3'b010,
        RSH_OPEN_SC = 3'b011,
        RSH_OPEN_SS = 3'b100,
        RSH_SETTLE = 3'b101,
        RSH_OPEN_REST = 3'b110
    } rsh_state_e;
endpackage : rsh_pkg
`default_nettype wire

// >>> hw/rsh_sync.sv
// Two-flop synchroniser for one level
`default_nettype none
module rsh_sync (
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Level
    input wire logic d_in,
    input wire logic rst_val_in,
    output logic q_out
);
    logic meta_r;

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            meta_r <= rst_val_in;
            q_out <= rst_val_in;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule : rsh_sync
`default_nettype wire

// >>> hw/rsh_top.sv
// Relay sequencing, bleed, interlocks and handler I/O
`default_nettype none
module rsh_top
    import rsh_pkg::*;
#(
    parameter int unsigned BLEED_CNT = BLEED_CYCLES,
    parameter int unsigned SETTLE_CNT = SETTLE_CYCLES,
    parameter int unsigned STEP_CNT = RELAY_STEP_CYCLES
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Register port
    input wire rsh_pkg::rsh_bus_s bus_in,
    output logic [31:0] rdata_out,
    // Measurement side
    input wire logic meas_done_in,
    input wire logic signed [31:0] meas_val_in,
    // Handler and fixture pins
    input wire logic trig_dio_in,
    input wire logic trig_aux_in,
    input wire logic trig_ilk_in,
    input wire logic module_ilk_in,
    output logic trig_go_out,
    output logic trig_out,
    output rsh_pkg::rsh_limit_s limit_out,
    // Relay drive
    output logic [CHAN_COUNT:1] relay_out,
    output logic bleed_out,
    output logic [15:0] vsrc_set_out,
    output logic [15:0] isrc_set_out,
    output logic signed [31:0] result_out
);
    import rsh_pkg::*;

    function automatic logic [15:0] clamp16(input logic [31:0] v,
                                            input logic [15:0] lim);
        clamp16 = (v > {16'h0000, lim}) ? lim : v[15:0];
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic trig_dio_s, trig_aux_s, trig_ilk_s, mod_ilk_s;
    rsh_sync u_s0 (.clock_in(clock_in), .nrst_in(nrst_in),
        .d_in(trig_dio_in), .rst_val_in(1'b0), .q_out(trig_dio_s));
    rsh_sync u_s1 (.clock_in(clock_in), .nrst_in(nrst_in),
        .d_in(trig_aux_in), .rst_val_in(1'b0), .q_out(trig_aux_s));
    rsh_sync u_s2 (.clock_in(clock_in), .nrst_in(nrst_in),
        .d_in(trig_ilk_in), .rst_val_in(1'b0), .q_out(trig_ilk_s));
    rsh_sync u_s3 (.clock_in(clock_in), .nrst_in(nrst_in),
        .d_in(module_ilk_in), .rst_val_in(1'b0), .q_out(mod_ilk_s));

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [15:0] vsrc_r, isrc_r;
    logic signed [31:0] hi1_r, hi2_r, lo1_r, lo2_r;
    logic wr_ctrl, wr_push, wr_cmd, wr_open1;
    assign wr_ctrl = bus_in.wr && bus_in.addr == REG_CTRL;
    assign wr_push = bus_in.wr && bus_in.addr == REG_LIST_PUSH;
    assign wr_cmd = bus_in.wr && bus_in.addr == REG_CMD;
    assign wr_open1 = bus_in.wr && bus_in.addr == REG_OPEN_ONE;

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            ctrl_r <= CTRL_RESET;
            vsrc_r <= 16'h0000;
            isrc_r <= 16'h0000;
            hi1_r <= 32'sh7FFF_FFFF;
            hi2_r <= 32'sh7FFF_FFFF;
            lo1_r <= 32'sh8000_0000;
            lo2_r <= 32'sh8000_0000;
        end else if (bus_in.wr) begin
            case (bus_in.addr)
                REG_CTRL: ctrl_r <= {29'h0, bus_in.wdata[2:0]};
                REG_VSRC: vsrc_r <= clamp16(bus_in.wdata, VSRC_MAX_V);
                REG_ISRC: isrc_r <= clamp16(bus_in.wdata, ISRC_MAX_MA);
                REG_HI1: hi1_r <= bus_in.wdata;
                REG_HI2: hi2_r <= bus_in.wdata;
                REG_LO1: lo1_r <= bus_in.wdata;
                REG_LO2: lo2_r <= bus_in.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            vsrc_set_out <= 16'h0000;
            isrc_set_out <= 16'h0000;
        end else begin
            vsrc_set_out <= vsrc_r;
            isrc_set_out <= isrc_r;
        end
    end

    // ------------------------------------------------------------
    // Close list and relay sequencer
    // ------------------------------------------------------------
    rsh_state_e state_r;
    logic [LIST_AW-1:0] wp_r, rp_r;
    logic [LIST_AW:0] cnt_r;
    logic [CHW-1:0] list_ch;
    logic [22:0] tmr_r;
    logic [CHAN_COUNT:1] rly_r;
    logic [CHAN_COUNT:1] ilk_mask;
    logic push_ok;

    assign push_ok = wr_push && cnt_r < (LIST_AW+1)'(LIST_DEPTH)
        && state_r == RSH_IDLE;

    rsh_list_mem #(.DW(CHW), .AW(LIST_AW)) u_mem (
        .clock_in(clock_in),
        .wr_in(push_ok),
        .waddr_in(wp_r),
        .wdata_in(bus_in.wdata[CHW-1:0]),
        .raddr_in(rp_r),
        .rdata_out(list_ch)
    );

    always_comb begin
        ilk_mask = '1;
        if (!mod_ilk_s) begin
            ilk_mask[CH_METER] = 1'b0;
            ilk_mask[CH_BACKPLANE] = 1'b0;
            ilk_mask[CH_SRC_CONN] = 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            state_r <= RSH_IDLE;
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            tmr_r <= '0;
            rly_r <= '0;
        end else begin
            if (push_ok) begin
                wp_r <= wp_r + 1'b1;
            end
            case (state_r)
                RSH_IDLE: begin
                    if (wr_cmd && bus_in.wdata[CMD_OPEN_ALL]) begin
                        state_r <= RSH_OPEN_SC;
                    end else if (wr_cmd && bus_in.wdata[CMD_CLOSE_LIST]
                                 && cnt_r != '0) begin
                        state_r <= RSH_CLOSE;
                    end else if (wr_open1 && bus_in.wdata[CHW-1:0] >= 5'd1
                                 && bus_in.wdata[CHW-1:0] <= 5'd24) begin
                        rly_r[bus_in.wdata[CHW-1:0]] <= 1'b0;
                    end
                    if (push_ok) begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                RSH_CLOSE: begin
                    // Memory read data lag one cycle behind rp_r
                    state_r <= RSH_STEP;
                    tmr_r <= 23'(STEP_CNT);
                end
                RSH_STEP: begin
                    if (tmr_r == 23'(STEP_CNT)) begin
                        if (list_ch >= 5'd1 && list_ch <= 5'd24) begin
                            rly_r[list_ch] <= 1'b1;
                        end
                    end
                    if (tmr_r == '0) begin
                        rp_r <= rp_r + 1'b1;
                        cnt_r <= cnt_r - 1'b1;
                        state_r <= (cnt_r == 5'd1) ? RSH_IDLE : RSH_CLOSE;
                    end else begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
                RSH_OPEN_SC: begin
                    rly_r[CH_SRC_CONN] <= 1'b0;
                    state_r <= RSH_OPEN_SS;
                end
                RSH_OPEN_SS: begin
                    rly_r[CH_SRC_SEL] <= 1'b0;
                    tmr_r <= 23'(SETTLE_CNT - 1);
                    state_r <= RSH_SETTLE;
                end
                RSH_SETTLE: begin
                    if (tmr_r == '0) begin
                        state_r <= RSH_OPEN_REST;
                    end else begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
                RSH_OPEN_REST: begin
                    rly_r <= '0;
                    rp_r <= wp_r;
                    cnt_r <= '0;
                    state_r <= RSH_IDLE;
                end
                default: state_r <= RSH_IDLE;
            endcase
            if (!mod_ilk_s) begin
                // Refusal applies even to a list step in flight
                rly_r[CH_METER] <= 1'b0;
                rly_r[CH_BACKPLANE] <= 1'b0;
                rly_r[CH_SRC_CONN] <= 1'b0;
            end
        end
    end

    // Ch 22 off = voltage source, on = current source; shunts 3/6/9/12
    // pass straight to their own relay drivers.
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            relay_out <= '0;
        end else begin
            relay_out <= rly_r & ilk_mask;
        end
    end

    // ------------------------------------------------------------
    // Bleed timer
    // ------------------------------------------------------------
    logic [22:0] bleed_tmr_r;
    logic sel_fall;
    assign sel_fall = relay_out[CH_SRC_SEL] && !(rly_r[CH_SRC_SEL]
        & ilk_mask[CH_SRC_SEL]);

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            bleed_tmr_r <= '0;
        end else if (sel_fall) begin
            bleed_tmr_r <= 23'(BLEED_CNT);
        end else if (bleed_tmr_r != '0) begin
            bleed_tmr_r <= bleed_tmr_r - 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            bleed_out <= 1'b0;
        end else begin
            bleed_out <= sel_fall || bleed_tmr_r > 23'd1
                || ctrl_r[CTRL_BLEED];
        end
    end

    // ------------------------------------------------------------
    // Triggers, limits and math
    // ------------------------------------------------------------
    logic trig_any;
    assign trig_any = trig_dio_s | trig_aux_s;

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            trig_go_out <= 1'b0;
            trig_out <= 1'b0;
        end else begin
            trig_go_out <= trig_any && trig_ilk_s;
            trig_out <= meas_done_in;
        end
    end

    logic h1, h2, l1, l2, pl;
    assign h1 = meas_val_in > hi1_r;
    assign h2 = meas_val_in > hi2_r;
    assign l1 = meas_val_in < lo1_r;
    assign l2 = meas_val_in < lo2_r;
    assign pl = ctrl_r[CTRL_POL_LOW];

    logic [4:0] fail_r;
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            fail_r <= 5'h00;
        end else if (meas_done_in) begin
            fail_r <= {h1, h2, l1, l2, h1 | h2 | l1 | l2};
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            limit_out <= '0;
        end else begin
            limit_out <= fail_r ^ {5{pl}};
        end
    end

    // Integer ratio; a zero reading leaves the previous result
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            result_out <= 32'sh0000_0000;
        end else if (meas_done_in && ctrl_r[CTRL_MATH]
                     && meas_val_in != 32'sh0) begin
            result_out <= -($signed({16'h0000, vsrc_r}) / meas_val_in);
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (bus_in.rd) begin
            case (bus_in.addr)
                REG_CTRL: rdata_out <= ctrl_r;
                REG_VSRC: rdata_out <= {16'h0000, vsrc_r};
                REG_ISRC: rdata_out <= {16'h0000, isrc_r};
                REG_HI1: rdata_out <= hi1_r;
                REG_HI2: rdata_out <= hi2_r;
                REG_LO1: rdata_out <= lo1_r;
                REG_LO2: rdata_out <= lo2_r;
                REG_RELAYS: rdata_out <= {7'h00, relay_out, 1'b0};
                REG_STATUS: rdata_out <= {20'h0, cnt_r, state_r,
                    bleed_out, trig_ilk_s, mod_ilk_s, 1'b0};
                REG_RESULT: rdata_out <= result_out;
                default: rdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_ilk_forces_open: assert property (@(posedge clock_in)
        disable iff (!nrst_in) !mod_ilk_s |=> !relay_out[CH_METER]
        && !relay_out[CH_BACKPLANE] && !relay_out[CH_SRC_CONN])
        else $error("interlock channel closed while loop open");
    a_bleed_starts: assert property (@(posedge clock_in)
        disable iff (!nrst_in) sel_fall |=> bleed_out [*8])
        else $error("bleed not held after source select opened");
    a_bleed_manual: assert property (@(posedge clock_in)
        disable iff (!nrst_in) ctrl_r[CTRL_BLEED] |=> bleed_out)
        else $error("manual bleed not honoured");
    a_openall_order: assert property (@(posedge clock_in)
        disable iff (!nrst_in) state_r == RSH_OPEN_SC |=>
        state_r == RSH_OPEN_SS ##1 state_r == RSH_SETTLE
        && !rly_r[CH_SRC_CONN] && !rly_r[CH_SRC_SEL])
        else $error("open-all order broken");
    a_vsrc_clamp: assert property (@(posedge clock_in)
        disable iff (!nrst_in) vsrc_r <= VSRC_MAX_V)
        else $error("voltage setpoint above limit");
    a_isrc_clamp: assert property (@(posedge clock_in)
        disable iff (!nrst_in) isrc_r <= ISRC_MAX_MA)
        else $error("current setpoint above limit");
    // Polarity seen by the output flop is the one of the cycle before
    a_master_or: assert property (@(posedge clock_in)
        disable iff (!nrst_in) (limit_out.master ^ $past(pl)) ==
        ((limit_out.hi1 ^ $past(pl)) | (limit_out.hi2 ^ $past(pl))
        | (limit_out.lo1 ^ $past(pl)) | (limit_out.lo2 ^ $past(pl))))
        else $error("master is not the OR of limits");
    a_trig_locked: assert property (@(posedge clock_in)
        disable iff (!nrst_in) !trig_ilk_s |=> !trig_go_out)
        else $error("trigger passed while interlocked");
    a_trig_done: assert property (@(posedge clock_in)
        disable iff (!nrst_in) meas_done_in |=> trig_out)
        else $error("no trigger out after measurement");
    a_trig_merge: assert property (@(posedge clock_in)
        disable iff (!nrst_in) trig_aux_s && trig_ilk_s |=> trig_go_out)
        else $error("aux trigger not accepted");
endmodule : rsh_top
`default_nettype wire

// >>> sim/rsh_handler_model.sv
// Handler and fixture model: trigger pins, interlocks, pulse counter
`default_nettype none
module rsh_handler_model (
    // Clock
    input wire logic clock_in,
    // Trigger and interlock pins
    output logic trig_dio_out,
    output logic trig_aux_out,
    output logic trig_ilk_out,
    output logic module_ilk_out,
    // Measurement-done pulse from the block
    input wire logic trig_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int pulse_cnt = 0;
    // Open trigger interlock pin floats high; shield loop starts open
    initial begin
        trig_dio_out = 1'b0;
        trig_aux_out = 1'b0;
        trig_ilk_out = 1'b1;
        module_ilk_out = 1'b0;
    end
    task automatic set_pins(input logic d, a, ti, mi);
        @(posedge clock_in);
        trig_dio_out <= d;
        trig_aux_out <= a;
        trig_ilk_out <= ti;
        module_ilk_out <= mi;
    endtask
    always @(posedge clock_in) begin
        if (trig_in === 1'b1) begin
            pulse_cnt++;
        end
    end
endmodule // rsh_handler_model
`default_nettype wire

// >>> sim/rsh_top_tb.sv
// Self-checking bench for the relay safety handler block
`default_nettype none
module rsh_top_tb import rsh_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    // Short counts keep the run small
    localparam int BL = 20;
    localparam int ST = 40;
    typedef struct packed {
        logic signed [31:0] v;
        logic [4:0] e;
    } rsh_row_s;
    rsh_row_s rows [5] = '{'{32'sh32, 5'h00}, '{32'sh96, 5'h11},
        '{32'shFA, 5'h19}, '{-32'sh96, 5'h05}, '{-32'shFA, 5'h07}};
    logic [4:0] chans [9] = '{5'h03, 5'h06, 5'h01, 5'h15, 5'h16, 5'h08,
        5'h17, 5'h10, 5'h12};
    logic clock_in = 1'b0;
    logic nrst_in = 1'b0;
    logic meas_done_in = 1'b0;
    logic signed [31:0] meas_val_in = '0;
    rsh_bus_s bus_in = '0;
    logic [31:0] rdata_out;
    logic trig_go_out;
    logic trig_out;
    logic bleed_out;
    rsh_limit_s limit_out;
    logic [CHAN_COUNT:1] relay_out;
    logic [15:0] vs;
    logic [15:0] is;
    logic signed [31:0] result_out;
    wire logic tdio;
    wire logic taux;
    wire logic tilk;
    wire logic milk;
    int mismatches = 0;
    int num_checks = 0;
    int n;
    int n2;
    logic [31:0] rd_d;

    always #4 clock_in = ~clock_in;

    rsh_top #(.BLEED_CNT(BL), .SETTLE_CNT(ST), .STEP_CNT(2)) dut_u (
        .clock_in(clock_in), .nrst_in(nrst_in), .bus_in(bus_in),
        .rdata_out(rdata_out), .meas_done_in(meas_done_in),
        .meas_val_in(meas_val_in), .trig_dio_in(tdio), .trig_aux_in(taux),
        .trig_ilk_in(tilk), .module_ilk_in(milk), .trig_go_out(trig_go_out),
        .trig_out(trig_out), .limit_out(limit_out), .relay_out(relay_out),
        .bleed_out(bleed_out), .vsrc_set_out(vs), .isrc_set_out(is),
        .result_out(result_out));
    rsh_handler_model handler_u (
        .clock_in(clock_in), .trig_dio_out(tdio), .trig_aux_out(taux),
        .trig_ilk_out(tilk), .module_ilk_out(milk), .trig_in(trig_out));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clock_in);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_in);
        bus_in.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_in);
        bus_in <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock_in);
        bus_in.rd <= 1'b0;
        #1;
        d = rdata_out;
    endtask
    // Bounded wait on one relay coil
    task automatic wait_bit(input int i, input logic v, input int lim);
        n = 0;
        while (relay_out[i] !== v && n < lim) begin
            cyc(1);
            n++;
        end
        if (n >= lim) begin
            chk(32'(relay_out[i]), 32'(v));
            end_of_test();
        end
    endtask
    task automatic meas(input logic signed [31:0] v);
        @(posedge clock_in);
        meas_done_in <= 1'b1;
        meas_val_in <= v;
        @(posedge clock_in);
        meas_done_in <= 1'b0;
        #1;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clock_in);
        nrst_in <= 1'b1;
        cyc(1);
        chk(32'(relay_out), 32'h0);
        chk(32'(limit_out), 32'h0);
        rd(8'hFC, rd_d);
        chk(rd_d, 32'h0);
        wr(REG_HI1, 32'h64);
        wr(REG_HI2, 32'hC8);
        wr(REG_LO1, 32'hFFFF_FF9C);
        wr(REG_LO2, 32'hFFFF_FF38);
        foreach (rows[i]) begin
            meas(rows[i].v);
            chk(32'(trig_out), 32'h1);
            cyc(2);
            chk(32'(limit_out), 32'(rows[i].e));
        end
        chk(handler_u.pulse_cnt, 32'h5);
        wr(REG_CTRL, 32'h2);
        cyc(3);
        chk(32'(limit_out), 32'(5'(~rows[4].e)));
        $display("test limits done");
        wr(REG_VSRC, 32'h258);
        wr(REG_ISRC, 32'h3C);
        cyc(2);
        chk(32'(vs), 32'h1F4);
        chk(32'(is), 32'h32);
        wr(REG_VSRC, 32'h64);
        wr(REG_CTRL, 32'h4);
        meas(-32'sh32);
        cyc(2);
        chk(32'(vs), 32'h64);
        rd(REG_VSRC, rd_d);
        chk(rd_d, 32'h64);
        chk(result_out, 32'h2);
        wr(REG_CTRL, 32'h0);
        $display("test setpoints done");
        handler_u.set_pins(1'b0, 1'b1, 1'b0, 1'b1);
        cyc(5);
        chk(32'(trig_go_out), 32'h0);
        handler_u.set_pins(1'b0, 1'b1, 1'b1, 1'b1);
        cyc(5);
        chk(32'(trig_go_out), 32'h1);
        handler_u.set_pins(1'b1, 1'b0, 1'b1, 1'b1);
        cyc(5);
        chk(32'(trig_go_out), 32'h1);
        handler_u.set_pins(1'b0, 1'b0, 1'b1, 1'b1);
        cyc(5);
        chk(32'(trig_go_out), 32'h0);
        $display("test triggers done");
        // Insulation path plus both bridgewire shunts
        foreach (chans[i]) wr(REG_LIST_PUSH, 32'(chans[i]));
        wr(REG_CMD, 32'h1);
        wait_bit(1, 1'b1, 100);
        chk(32'(relay_out[21]), 32'h0);
        wait_bit(18, 1'b1, 100);
        chk(32'(relay_out), 32'h7280A5);
        handler_u.set_pins(1'b0, 1'b0, 1'b1, 1'b0);
        cyc(5);
        chk(32'(relay_out), 32'h6080A5);
        handler_u.set_pins(1'b0, 1'b0, 1'b1, 1'b1);
        cyc(5);
        chk(32'(relay_out), 32'h6080A5);
        wr(REG_OPEN_ONE, 32'h3);
        cyc(3);
        chk(32'(relay_out), 32'h6080A1);
        $display("test relays done");
        wr(REG_LIST_PUSH, 32'h15);
        wr(REG_CMD, 32'h1);
        wait_bit(21, 1'b1, 50);
        // Cable relays stay closed until the source is removed
        wr(REG_CMD, 32'h2);
        wait_bit(21, 1'b0, 20);
        chk(32'(relay_out[22]), 32'h1);
        wait_bit(22, 1'b0, 20);
        cyc(1);
        chk(32'(bleed_out), 32'h1);
        n2 = 1;
        while (bleed_out === 1'b1 && n2 < 100) begin
            cyc(1);
            n2++;
        end
        chk(32'(n2 >= BL - 2 && n2 <= BL + 1), 32'h1);
        chk(32'(relay_out[1]), 32'h1);
        wait_bit(1, 1'b0, 100);
        chk(32'(relay_out), 32'h0);
        $display("test open all done");
        wr(REG_CTRL, 32'h1);
        cyc(3 * BL);
        chk(32'(bleed_out), 32'h1);
        wr(REG_CTRL, 32'h0);
        cyc(3);
        chk(32'(bleed_out), 32'h0);
        $display("test manual bleed done");
        end_of_test();
    end
endmodule // rsh_top_tb
`default_nettype wire
